// *** core/adc_serial_instruction_interface.sv ***
// Serial instruction and result interface with conversion sequencing.
`timescale 1ns/1ps
`default_nettype none
`include "adc_sii_regs.svh"

// Behaviour
// - First instruction after reset starts calibration.
// - Calibration garbles output; second status read valid.
// - Calibration busy bit drops when calibration ends.
// - Chip select falling mid-conversion aborts it.
// - End of conversion flag is provided.
// - Result shifts out with the next instruction.
// - Format sets next exchange's clock count.
// - Twelve bits unsigned needs 12 pulses.
// - Twelve bits signed needs 13 pulses.
// - Sixteen bits needs 16, signed 17.
// - After reset exchanges are 13 pulses.
// - Reset defaults: signed, MSB first, 10 cycles.
// - Acquisition and sign instructions start nothing.
// - Acquisition lasts 6, 10, 18 or 34 cycles.
// - Conversion instruction reselects channel, then converts.
// - Power-down stops converter, serial link stays.
// - Pin power-down overrides software power-up.
// - Software power-down ends by instruction or pin pulse.
// - Power-down disrupts a running conversion.
module adc_serial_instruction_interface #(
  parameter logic [7:0] CONV_CONVERTER_CLOCK = `SII_CONV_CONVERTER_CLOCK,
  parameter logic [7:0] CAL_CONVERTER_CLOCK  = `SII_CAL_CONVERTER_CLOCK
) (
  // Reference clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Serial link.
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_serial_instr_in,
  output logic             o_dout,
  // Converter pins and analog core.
  input  wire logic        i_converter_clock,
  input  wire logic        i_sleep_pin,
  input  wire logic [12:0] i_sample_data,
  // Status outputs.
  output logic             o_eoc,
  output logic             o_cal_busy,
  output logic             o_powered_down,
  output logic             o_result_valid,
  output logic             o_test_mode,
  output logic             o_autozero,
  output logic [3:0]       o_mux_addr,
  output logic [4:0]       o_word_len
);

  // =====================================================
  // Helpers

  // Expected exchange length for a format.
  function automatic logic [4:0] len_of(input logic f16, input logic s);
    len_of = (f16 ? `SII_LEN_BASE16 : `SII_LEN_BASE12) + {4'h0, s};
  endfunction : len_of

  // Acquisition length for a selector.
  function automatic logic [7:0] acq_of(input logic [1:0] sel);
    case (sel)
      2'h0:    acq_of = `SII_ACQ6;
      2'h1:    acq_of = `SII_ACQ10;
      2'h2:    acq_of = `SII_ACQ18;
      default: acq_of = `SII_ACQ34;
    endcase
  endfunction : acq_of

  // Places a value so that its first bit to send sits at bit 16.
  function automatic logic [16:0] fmt_word(input logic [12:0] v, input logic s,
                                           input logic f16, input logic msb);
    logic [16:0] ext;
    logic [16:0] w;
    int          n;
    ext = {{4{v[12]}}, v};
    w   = 17'h00000;
    n   = int'(len_of(f16, s));
    for (int i = 0; i < 17; i++)
    begin
      if (i < n)
      begin
        w[16-i] = msb ? ext[n-1-i] : ext[i];
      end
    end
    return w;
  endfunction : fmt_word

  // =====================================================
  // Link domain

  adc_sii_pkg::link_state_t  lk;      // Link state.
  adc_sii_pkg::link_state_t  next_lk; // Next link state.
  adc_sii_pkg::core_state_t  cs;      // Core state.
  adc_sii_pkg::core_state_t  next_cs; // Next core state.
  logic                      link_clr;     // Asynchronous link clear.
  logic                      evt_toggle;   // Flips per received instruction.
  logic [6:0]                instr_sh;     // Instruction bits in flight.
  logic [7:0]                instr;        // Last whole instruction.
  logic [4:0]                cur_len;      // Length of this exchange.

  // Chip select high or core reset ends any frame at once.
  assign link_clr = i_cs_n | cs.link_clr;

  // The first edge of an exchange latches the length set by the last one.
  assign cur_len = (lk.cnt == 5'h00) ? len_of(cs.fmt16, cs.sign_on) : lk.exp_len;

  // Counts pulses, loads the output word and shifts it out.
  always_comb
  begin
    next_lk = lk;
    if (lk.cnt == 5'h00)
    begin
      // Word is sampled at the first edge only; core updates during the frame wait for the next one.
      next_lk.exp_len = cur_len;
      next_lk.shreg   = {cs.out_word[15:0], 1'b0};
      next_lk.dout    = cs.out_word[16];
    end
    else
    begin
      next_lk.shreg = {lk.shreg[15:0], 1'b0};
      next_lk.dout  = lk.shreg[16];
    end
    // Wrap at the expected count so continuous frames stay aligned.
    if (lk.cnt + 5'h01 == cur_len)
    begin
      next_lk.cnt = 5'h00;
    end
    else
    begin
      next_lk.cnt = lk.cnt + 5'h01;
    end
  end

  // Link registers, cleared without a clock edge between frames.
  always_ff @(posedge i_sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      lk <= '0;
    end
    else
    begin
      lk <= next_lk;
    end
  end

  // Instruction capture survives chip select so the core can read it.
  always_ff @(posedge i_sclk or posedge cs.link_clr)
  begin
    if (cs.link_clr)
    begin
      evt_toggle <= 1'b0;
      instr_sh   <= 7'h00;
      instr      <= 8'h00;
    end
    else if (!i_cs_n && lk.cnt < `SII_INSTR_BITS)
    begin
      // Bit 0 of the instruction arrives first; bit 7 goes straight to the word.
      if (lk.cnt == `SII_INSTR_BITS - 5'h01)
      begin
        instr      <= {i_serial_instr_in, instr_sh};
        evt_toggle <= ~evt_toggle;
      end
      else
      begin
        instr_sh[lk.cnt[2:0]] <= i_serial_instr_in;
      end
    end
  end

  // =====================================================
  // Core domain

  logic                      new_instr;  // One instruction arrived.
  logic                      converter_clock_edge;  // Converter clock rose.
  logic                      cs_fall;    // Chip select fell.
  logic                      pin_fall;   // Sleep pin fell.
  logic                      powered;    // Converter is powered.
  logic                      busy;       // Calibration or conversion runs.
  logic [3:0]                op;         // Opcode, bit 4 leftmost.
  logic [12:0]               status;     // Status value.

  assign new_instr = cs.tg_sync ^ cs.tg_prev;
  assign converter_clock_edge = cs.ck_sync & ~cs.ck_prev;
  assign cs_fall   = cs.cs_prev & ~cs.cs_sync;
  assign pin_fall  = cs.pd_prev & ~cs.pd_sync;
  assign powered   = ~cs.pd_sync & ~cs.sw_pd;
  assign busy      = cs.state != adc_sii_pkg::ST_IDLE;
  assign op        = {instr[4], instr[5], instr[6], instr[7]};
  assign status    = {4'h0, cs.test_mode, cs.msb_first, cs.sign_on, cs.fmt16,
                      ~cs.fmt16, 1'b0, cs.state == adc_sii_pkg::ST_CAL, ~powered, 1'b0};

  // Synchronisers, instruction decode and the conversion sequencer.
  always_comb
  begin
    next_cs = cs;
    // Two flops on chip select, sleep pin, converter clock and toggle before any logic.
    next_cs.cs_meta = i_cs_n;
    next_cs.cs_sync = cs.cs_meta;
    next_cs.cs_prev = cs.cs_sync;
    next_cs.pd_meta = i_sleep_pin;
    next_cs.pd_sync = cs.pd_meta;
    next_cs.pd_prev = cs.pd_sync;
    next_cs.ck_meta = i_converter_clock;
    next_cs.ck_sync = cs.ck_meta;
    next_cs.ck_prev = cs.ck_sync;
    next_cs.tg_meta = evt_toggle;
    next_cs.tg_sync = cs.tg_meta;
    next_cs.tg_prev = cs.tg_sync;
    next_cs.link_clr = 1'b0;
    // Pin pulse ends a software power-down.
    if (pin_fall)
    begin
      next_cs.sw_pd = 1'b0;
    end
    // Converter timing advances on converter clock edges.
    if (converter_clock_edge && busy)
    begin
      next_cs.timer = cs.timer + 8'h01;
      case (cs.state)
        adc_sii_pkg::ST_CAL:
        begin
          if (cs.timer == CAL_CONVERTER_CLOCK - 8'h01)
          begin
            next_cs.state = adc_sii_pkg::ST_IDLE;
          end
        end
        adc_sii_pkg::ST_ACQ:
        begin
          if (cs.timer == acq_of(cs.acq_sel) - 8'h01)
          begin
            next_cs.state = adc_sii_pkg::ST_CONV;
            next_cs.timer = 8'h00;
          end
        end
        adc_sii_pkg::ST_CONV:
        begin
          if (cs.timer == CONV_CONVERTER_CLOCK - 8'h01)
          begin
            // Result waits for the next exchange.
            next_cs.state        = adc_sii_pkg::ST_IDLE;
            next_cs.eoc          = 1'b1;
            next_cs.result_valid = 1'b1;
            next_cs.out_word     = fmt_word(i_sample_data, cs.sign_on,
                                            cs.fmt16, cs.msb_first);
          end
        end
        default:
        begin
          next_cs.state = adc_sii_pkg::ST_IDLE;
        end
      endcase
    end
    // Strobing chip select ends a running conversion early.
    if (cs_fall && (cs.state == adc_sii_pkg::ST_ACQ || cs.state == adc_sii_pkg::ST_CONV))
    begin
      next_cs.state        = adc_sii_pkg::ST_IDLE;
      next_cs.eoc          = 1'b1;
      next_cs.result_valid = 1'b0;
    end
    // Instruction decode.
    if (new_instr)
    begin
      if (!cs.first_done)
      begin
        // The very first instruction always calibrates.
        next_cs.first_done = 1'b1;
        next_cs.state      = adc_sii_pkg::ST_CAL;
        next_cs.timer      = 8'h00;
        next_cs.out_word   = 17'h00000;
      end
      else if (!op[3])
      begin
        // Conversion: new format, channel latched before sampling.
        next_cs.fmt16     = instr[7];
        next_cs.msb_first = ~instr[5];
        next_cs.mux_addr  = instr[3:0];
        if (powered)
        begin
          next_cs.state = adc_sii_pkg::ST_ACQ;
          next_cs.timer = 8'h00;
          next_cs.eoc   = 1'b0;
        end
      end
      else
      begin
        // Configuration instructions other than calibration and power-down leave the sequencer alone.
        case (op)
          `SII_OP_CAL:
          begin
            if (powered)
            begin
              next_cs.state    = adc_sii_pkg::ST_CAL;
              next_cs.timer    = 8'h00;
              next_cs.out_word = 17'h00000;
            end
          end
          `SII_OP_ZERO:   next_cs.autozero = 1'b1;
          `SII_OP_PWRUP:  next_cs.sw_pd    = 1'b0;
          `SII_OP_PWRDN:  next_cs.sw_pd    = 1'b1;
          `SII_OP_STATUS: next_cs.out_word = fmt_word(status, cs.sign_on,
                                                      cs.fmt16, cs.msb_first);
          `SII_OP_SIGN:   next_cs.sign_on  = instr[0];
          `SII_OP_ACQ:    next_cs.acq_sel  = {instr[0], instr[1]};
          `SII_OP_MODE:   next_cs.test_mode = instr[0];
          default:        next_cs.autozero = cs.autozero;
        endcase
      end
    end
    // Power loss stops the converter; the link keeps running.
    if (!powered && busy)
    begin
      next_cs.state        = adc_sii_pkg::ST_IDLE;
      next_cs.result_valid = 1'b0;
      next_cs.eoc          = 1'b1;
    end
    if (!i_rst_n)
    begin
      // Power-on defaults.
      next_cs           = '0;
      next_cs.link_clr  = 1'b1;
      next_cs.cs_meta   = 1'b1;
      next_cs.cs_sync   = 1'b1;
      next_cs.cs_prev   = 1'b1;
      next_cs.sign_on   = 1'b1;
      next_cs.msb_first = 1'b1;
      next_cs.acq_sel   = `SII_ACQ_RESET;
      next_cs.eoc       = 1'b1;
    end
  end

  // Core registers.
  always_ff @(posedge i_ref_clk)
  begin
    cs <= next_cs;
  end

  // =====================================================
  // Outputs

  assign o_dout         = lk.dout;
  assign o_eoc          = cs.eoc;
  assign o_cal_busy     = cs.state == adc_sii_pkg::ST_CAL;
  assign o_powered_down = ~powered;
  assign o_result_valid = cs.result_valid;
  assign o_test_mode    = cs.test_mode;
  assign o_autozero     = cs.autozero;
  assign o_mux_addr     = cs.mux_addr;
  assign o_word_len     = len_of(cs.fmt16, cs.sign_on);

  // =====================================================
  // Assertions

  // An accepted conversion instruction.
  sequence s_conv_instr;
    new_instr && cs.first_done && !op[3] && powered && !cs_fall;
  endsequence

  property p_reset_len;
    @(posedge i_ref_clk) $rose(i_rst_n) |-> o_word_len == 5'h0D;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("Length not 13 after reset.");

  property p_first_cal;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      new_instr && !cs.first_done && powered |=> o_cal_busy && cs.out_word == 17'h00000;
  endproperty
  a_first_cal: assert property (p_first_cal) else $error("First instruction did not calibrate.");

  property p_cal_done;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(o_cal_busy) |-> cs.state == adc_sii_pkg::ST_IDLE && $past(cs.timer) == CAL_CONVERTER_CLOCK - 8'h01 || !powered;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("Calibration ended early.");

  property p_abort;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      cs_fall && (cs.state == adc_sii_pkg::ST_ACQ || cs.state == adc_sii_pkg::ST_CONV)
      |=> !busy && o_eoc && !o_result_valid;
  endproperty
  a_abort: assert property (p_abort) else $error("Conversion not aborted.");

  property p_config_quiet;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      new_instr && cs.first_done && (op == `SII_OP_ACQ || op == `SII_OP_SIGN) && !busy
      |=> !busy && $stable(cs.out_word);
  endproperty
  a_config_quiet: assert property (p_config_quiet) else $error("Configuration started a conversion.");

  property p_start;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_conv_instr |=> cs.state == adc_sii_pkg::ST_ACQ && o_mux_addr == $past(instr[3:0]) && !o_eoc;
  endproperty
  a_start: assert property (p_start) else $error("Conversion did not start.");

  property p_acq_len;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(cs.state == adc_sii_pkg::ST_CONV) |-> $past(cs.timer) == acq_of(cs.acq_sel) - 8'h01;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("Acquisition length wrong.");

  property p_pin_wins;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      cs.pd_sync || cs.sw_pd |-> o_powered_down ##1 !(cs.state == adc_sii_pkg::ST_CONV);
  endproperty
  a_pin_wins: assert property (p_pin_wins) else $error("Power-down not honoured.");

  property p_pin_pulse;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      pin_fall |=> !cs.sw_pd;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse) else $error("Pin pulse did not power up.");

  property p_frame_len;
    @(posedge i_sclk) disable iff (link_clr)
      lk.cnt == 5'h00 |=> lk.exp_len == $past(o_word_len);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("Frame length not latched.");

endmodule : adc_serial_instruction_interface
`default_nettype wire

// *** core/adc_sii_regs.svh ***
// Constants for the serial instruction interface of the converter.
`ifndef ADC_SII_REGS_SVH
`define ADC_SII_REGS_SVH

// =====================================================
// Exchange lengths in serial clock pulses.
`define SII_INSTR_BITS 5'h08
`define SII_LEN_BASE12 5'h0C
`define SII_LEN_BASE16 5'h10
`define SII_LEN_RESET 5'h0D

// =====================================================
// Acquisition lengths in converter clock cycles.
`define SII_ACQ6 8'h06
`define SII_ACQ10 8'h0A
`define SII_ACQ18 8'h12
`define SII_ACQ34 8'h22
`define SII_ACQ_RESET 2'h1

// =====================================================
// Conversion and calibration lengths in converter clock cycles.
`define SII_CONV_CONVERTER_CLOCK 8'h2C
`define SII_CAL_CONVERTER_CLOCK 8'h40

// =====================================================
// Opcodes carried on instruction bits 4..7, bit 4 leftmost.
`define SII_OP_CAL 4'h8
`define SII_OP_ZERO 4'h9
`define SII_OP_PWRUP 4'hA
`define SII_OP_PWRDN 4'hB
`define SII_OP_STATUS 4'hC
`define SII_OP_SIGN 4'hD
`define SII_OP_ACQ 4'hE
`define SII_OP_MODE 4'hF

`endif

// *** core/adc_sii_pkg.sv ***
// Types shared by the serial instruction interface.
package adc_sii_pkg;
  // Converter activity.
  typedef enum logic [1:0] {ST_IDLE, ST_CAL, ST_ACQ, ST_CONV} conv_state_t;

  // Link side state, cleared whenever chip select is high.
  typedef struct packed {
    logic [4:0]  cnt;
    logic [4:0]  exp_len;
    logic [16:0] shreg;
    logic        dout;
  } link_state_t;

  // Reference clock side state.
  typedef struct packed {
    logic        cs_meta, cs_sync, cs_prev;
    logic        pd_meta, pd_sync, pd_prev;
    logic        ck_meta, ck_sync, ck_prev;
    logic        tg_meta, tg_sync, tg_prev;
    logic        link_clr;
    conv_state_t state;
    logic [7:0]  timer;
    logic        first_done, sign_on, fmt16, msb_first;
    logic        test_mode, autozero, sw_pd;
    logic [1:0]  acq_sel;
    logic [3:0]  mux_addr;
    logic [16:0] out_word;
    logic        result_valid, eoc;
  } core_state_t;
endpackage : adc_sii_pkg

// *** tb/host_link_model.sv ***
// Host controller model that drives serial link frames and captures the output word.
`timescale 1ns/1ps
`default_nettype none

// =========================================
// Host link model
module host_link_model (
  // Serial link towards the converter.
  input  wire logic        i_dout,
  output logic             o_sclk,
  output logic             o_cs_n,
  output logic             o_di,
  // Captured word and end of frame flag.
  output logic [16:0]      o_word,
  output logic             o_done
);

  // Idle levels: the clock stands low and chip select high between frames.
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_di   = 1'b1;
    o_word = '0;
    o_done = 1'b0;
  end

  // Sends one frame of n clock pulses, instruction bit 0 first.
  task automatic frame(input logic [7:0] ins, input int n);
    int k;
    o_done = 1'b0;
    o_word = '0;
    #37;
    o_cs_n = 1'b0;
    // Exactly n pulses; short frames only ever carry a full instruction.
    for (k = 0; k < n; k++)
    begin
      o_di = (k < 8) ? ins[k] : ~o_di;
      #80;
      o_sclk = 1'b1;
      #80;
      o_sclk = 1'b0;
      o_word = {o_word[15:0], i_dout};
    end
    #80;
    o_cs_n = 1'b1;
    // A deselected data line never keeps its last value.
    o_di   = ~o_di;
    o_done = 1'b1;
  endtask : frame

endmodule : host_link_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the serial instruction interface.
`timescale 1ns/1ps
`default_nettype none
`include "adc_sii_regs.svh"

// =========================================
// Testbench
module testbench;
  typedef struct {logic [16:0] v; logic [16:0] m;} note_t;
  localparam int CONV = 4;               // Shortened conversion length.
  logic        ref_clk, rst_n, converter_clock, sleep;
  logic [12:0] sample;                   // Sample seen by the converter.
  logic        sclk, cs_n, di, dout, done;
  logic [16:0] word;                     // Word captured by the host.
  logic        eoc, cal_busy, pd, rv, test, az;
  logic [3:0]  mux, mx;
  logic [4:0]  wlen;
  note_t       q[$];                     // Expected words, oldest first.
  note_t       nt;
  logic [16:0] prev_v, prev_m;
  int          errors, n_tests, cycles, i, k, cnt;
  int          acq_len [4] = '{6, 10, 18, 34};
  logic [3:0]  acq_low [4] = '{4'h0, 4'h2, 4'h1, 4'h3};

  adc_serial_instruction_interface #(.CONV_CONVERTER_CLOCK(8'(CONV))) i_adc_serial_instruction_interface (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_instr_in(di), .o_dout(dout), .i_converter_clock(converter_clock), .i_sleep_pin(sleep),
    .i_sample_data(sample), .o_eoc(eoc), .o_cal_busy(cal_busy), .o_powered_down(pd),
    .o_result_valid(rv), .o_test_mode(test), .o_autozero(az), .o_mux_addr(mux), .o_word_len(wlen));

  host_link_model host (.i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_di(di), .o_word(word), .o_done(done));

  // Reference clock at 125 MHz and converter clock at 5 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    converter_clock = 1'b0;
    forever #100 converter_clock = ~converter_clock;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Builds an instruction byte from an opcode and its low bits.
  function automatic logic [7:0] mk(input logic [3:0] op, input logic [3:0] low);
    return {op[0], op[1], op[2], op[3], low};
  endfunction : mk

  // Notes the expected word, runs a frame, then lets the decode settle.
  task automatic xfer(input logic [7:0] ins, input int n, input logic [16:0] v, input logic [16:0] m);
    q.push_back('{v, m});
    host.frame(ins, n);
    repeat (20) @(posedge ref_clk);
  endtask : xfer

  // Starts a conversion and counts converter clock rises from its start to its end.
  task automatic conv(input logic [7:0] ins, input int n, input logic [16:0] v, input logic [16:0] m);
    fork
      xfer(ins, n, v, m);
      begin
        wait (eoc === 1'b0);
        cnt = 0;
        // No new frame is sent until the conversion has ended.
        while (eoc !== 1'b1 && cnt < 100)
        begin
          @(posedge converter_clock);
          cnt++;
        end
      end
    join
    repeat (10) @(posedge ref_clk);
  endtask : conv

  // Moves the power-down pin and waits for it to be seen.
  task automatic pin(input logic v);
    @(posedge ref_clk);
    #1 sleep = v;
    repeat (10) @(posedge ref_clk);
  endtask : pin

  // Monitor: every finished frame with a nonzero mask is compared against the oldest note.
  always @(posedge done)
  begin
    nt = q.pop_front();
    if (nt.m !== 17'h0)
      chk("dout_word", word & nt.m, nt.v & nt.m);
  end

  // Cuts a hang short.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      stop_test();
    end
  end

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    sleep = 1'b0;
    sample = '0;
    k = $urandom(32'hD6B4BBEF);
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("word_len", 17'(wlen), 17'h0D);
    chk("idle_flags", 17'({eoc, cal_busy, pd, rv, test, az, mux}), 17'h200);
    $display("test reset done");
    // Any first instruction calibrates; the next status read is void.
    xfer(mk(`SII_OP_STATUS, 4'h0), 13, 17'h0, 17'h1FFF);
    chk("cal_busy", 17'(cal_busy), 17'h1);
    for (k = 0; k < 4000 && cal_busy !== 1'b0; k++)
      @(posedge ref_clk);
    chk("cal_done", 17'(cal_busy), 17'h0);
    xfer(mk(`SII_OP_STATUS, 4'h0), 13, 17'h0, 17'h1FFF);
    prev_v = 17'h00D0;
    prev_m = 17'h1FFE;
    xfer(mk(`SII_OP_STATUS, 4'h0), 13, prev_v, prev_m);
    $display("test calibration done");
    // Every acquisition length, each followed by a conversion.
    for (i = 0; i < 4; i++)
    begin
      xfer(mk(`SII_OP_ACQ, acq_low[i]), 8, prev_v >> 5, prev_m >> 5);
      chk("eoc_idle", 17'(eoc), 17'h1);
      @(posedge ref_clk);
      #1 sample = 13'($urandom);
      mx = 4'($urandom);
      conv({4'h0, mx}, 13, prev_v, prev_m);
      chk("acq_cycles", 17'(cnt >= acq_len[i] + CONV - 1 && cnt <= acq_len[i] + CONV + 2), 17'h1);
      chk("mux", 17'(mux), 17'(mx));
      chk("result_valid", 17'(rv), 17'h1);
      prev_v = 17'(sample);
      prev_m = 17'h1FFF;
    end
    $display("test acquisition done");
    // Format changes and the pulse count of the following frame.
    conv(8'h80, 13, prev_v, prev_m);
    chk("word_len", 17'(wlen), 17'h11);
    conv(8'h00, 17, {{4{sample[12]}}, sample}, 17'h1FFFF);
    chk("word_len", 17'(wlen), 17'h0D);
    xfer(mk(`SII_OP_SIGN, 4'h0), 8, 17'(sample) >> 5, 17'hFF);
    chk("word_len", 17'({eoc, wlen}), 17'h2C);
    conv(8'h80, 12, 17'h0, 17'h0);
    chk("word_len", 17'(wlen), 17'h10);
    xfer(mk(`SII_OP_SIGN, 4'h1), 8, 17'h0, 17'h0);
    chk("word_len", 17'(wlen), 17'h11);
    conv(8'h00, 17, 17'h0, 17'h0);
    $display("test formats done");
    // Chip select falling during acquisition ends the conversion early.
    xfer(8'h00, 13, 17'h0, 17'h0);
    repeat (3) @(posedge converter_clock);
    xfer(mk(`SII_OP_SIGN, 4'h1), 8, 17'h0, 17'h0);
    chk("abort", 17'({eoc, rv}), 17'h2);
    $display("test abort done");
    // Pin and instruction power-down arbitration.
    xfer(8'h00, 13, 17'h0, 17'h0);
    pin(1'b1);
    chk("pd_abort", 17'({pd, eoc, rv}), 17'h6);
    xfer(mk(`SII_OP_PWRUP, 4'h0), 8, 17'h0, 17'h0);
    xfer(mk(`SII_OP_SIGN, 4'h0), 8, 17'h0, 17'h0);
    chk("pd_link", 17'({pd, wlen}), 17'h2C);
    pin(1'b0);
    chk("pd", 17'(pd), 17'h0);
    xfer(mk(`SII_OP_PWRDN, 4'h0), 8, 17'h0, 17'h0);
    chk("pd", 17'(pd), 17'h1);
    pin(1'b1);
    pin(1'b0);
    chk("pd", 17'(pd), 17'h0);
    xfer(mk(`SII_OP_PWRDN, 4'h0), 8, 17'h0, 17'h0);
    chk("pd", 17'(pd), 17'h1);
    xfer(mk(`SII_OP_PWRUP, 4'h0), 8, 17'h0, 17'h0);
    chk("pd", 17'(pd), 17'h0);
    $display("test power done");
    // Auto zero and mode instructions only move their flags.
    xfer(mk(`SII_OP_ZERO, 4'h0), 8, 17'h0, 17'h0);
    chk("autozero", 17'({az, eoc}), 17'h3);
    xfer(mk(`SII_OP_MODE, 4'h1), 8, 17'h0, 17'h0);
    chk("test_mode", 17'(test), 17'h1);
    xfer(mk(`SII_OP_MODE, 4'h0), 8, 17'h0, 17'h0);
    chk("test_mode", 17'(test), 17'h0);
    $display("test flags done");
    stop_test();
  end

endmodule : testbench
`default_nettype wire
